// [logic/cefm_pkg.sv]
// Operation
// - Flag bit 7 sets on entering input overvoltage protection or sleep.
// - Flag bit 6 sets on battery discharge overcurrent or battery overvoltage.
// - Flag bit 5 sets when switching stops for system overvoltage or short.
// - Flag bit 4 sets when boost stops for reverse current or rail faults.
// - Flag bit 3 sets on the rising edge of die thermal shutdown.
// - Flag bit 0 sets on any change of thermistor temperature zone.
// - Mask A bit 6 gates conversion-done interrupt, one-shot mode only.
// - Mask A bit 5 gates the interrupt on entering die thermal regulation.
// - Mask A bit 4 gates interrupts on entering and leaving min-system regulation.
// - Mask A bit 3 gates input, limit-pin or boost current regulation entry.
// - Mask A bit 2 gates input or boost voltage regulation entry.
// - Mask A bit 1 gates fast, trickle or pre-charge timer expiry.
// - Mask A bit 0 gates host watchdog timer expiry.
// - Mask B bit 3 gates the interrupt on charging status change.
// - Mask B bit 0 gates the interrupt on input supply status change.
// - Mask A resets to zero; bit 7 reserved reads zero.
// - Fault mask bits 7:3 and 0 writable, reset zero; bits 2:1 read zero.
// - A fault mask bit at one stops its fault event from interrupting.
package cefm_pkg;

  localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h22;
  localparam logic [7:0] ADDR_MASK_A = 8'h23;
  localparam logic [7:0] ADDR_MASK_B = 8'h24;
  localparam logic [7:0] ADDR_FAULT_MASK = 8'h25;

  localparam logic [7:0] MASK_A_RESET = 8'h00;
  localparam logic [7:0] MASK_B_RESET = 8'h00;
  localparam logic [7:0] FAULT_MASK_RESET = 8'h00;
  localparam logic [7:0] FAULT_FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_A_WRITABLE = 8'h7F;
  localparam logic [7:0] MASK_B_WRITABLE = 8'h09;
  localparam logic [7:0] FAULT_MASK_WRITABLE = 8'hF9;

  localparam int FLT_INPUT_SUPPLY = 7;
  localparam int FLT_BATTERY = 6;
  localparam int FLT_SYSTEM_RAIL = 5;
  localparam int FLT_BOOST_OUTPUT = 4;
  localparam int FLT_DIE_OVERHEAT = 3;
  localparam int FLT_THERMISTOR = 0;

  localparam int MA_CONVERSION_DONE = 6;
  localparam int MA_THERMAL_REG = 5;
  localparam int MA_MIN_SYSTEM = 4;
  localparam int MA_INPUT_CURRENT = 3;
  localparam int MA_INPUT_VOLTAGE = 2;
  localparam int MA_CHARGE_TIMER = 1;
  localparam int MA_HOST_WATCHDOG = 0;
  localparam int MB_CHARGE_STATE = 3;
  localparam int MB_INPUT_SUPPLY = 0;

  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h5A;
  localparam int INT_PULSE_CYCLES = 64;

  typedef struct packed {
    logic input_overvoltage;
    logic input_sleep;
    logic battery_overcurrent;
    logic battery_overvoltage;
    logic system_overvoltage;
    logic system_short;
    logic boost_reverse_current;
    logic mid_node_undervoltage;
    logic mid_node_overvoltage;
    logic input_rail_undervoltage;
    logic input_rail_overvoltage;
    logic die_shutdown;
    logic [2:0] thermistor_zone;
  } cefm_fault_events_t;

  typedef struct packed {
    logic conversion_done;
    logic die_thermal_regulation;
    logic min_system_voltage_regulation;
    logic input_current_regulation;
    logic current_limit_pin_regulation;
    logic boost_current_regulation;
    logic input_voltage_regulation;
    logic boost_voltage_regulation;
    logic fast_timer_expired;
    logic trickle_timer_expired;
    logic precharge_timer_expired;
    logic host_watchdog_expired;
    logic [2:0] charge_state;
    logic [2:0] input_supply_state;
  } cefm_charger_events_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK,
    ST_READ_NEXT
  } cefm_link_state_t;

endpackage : cefm_pkg

// [logic/cefm_sync.sv]
`timescale 1ns/1ps
module cefm_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic clock_enable,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import cefm_pkg::*;

  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clock)
      begin
        if (!rst_b)
        begin
          meta[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else if (clock_enable)
        begin
          meta[i] <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule : cefm_sync

// [logic/cefm_event_edge.sv]
`timescale 1ns/1ps
module cefm_event_edge #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic clock_enable,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] change
);
  import cefm_pkg::*;

  logic armed;
  logic [2:0] warmup;
  logic [WIDTH-1:0] last;

  // Edges stay blocked until the two-stage synchroniser ahead has refilled
  // and the levels are learnt, so a condition already present at reset
  // does not look like a fresh event.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      warmup <= 3'b000;
    else if (clock_enable)
      warmup <= {warmup[1:0], 1'b1};
  end

  assign armed = warmup[2];

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clock)
      begin
        if (!rst_b)
          last[i] <= 1'b0;
        else if (clock_enable)
          last[i] <= level[i];
      end
      assign rise[i] = armed & clock_enable & level[i] & ~last[i];
      assign change[i] = armed & clock_enable & (level[i] ^ last[i]);
    end
  endgenerate

endmodule : cefm_event_edge

// [logic/cefm_flag_mask.sv]
`timescale 1ns/1ps
module cefm_flag_mask #(
  parameter logic [6:0] SLAVE_ADDR = cefm_pkg::SLAVE_ADDR_DEFAULT,
  parameter int PULSE_CYCLES = cefm_pkg::INT_PULSE_CYCLES
) (
  input wire logic clock,
  input wire logic clock_enable,
  input wire logic rst_b,
  input wire logic reg_reset,
  input wire logic one_shot_mode,
  input wire cefm_pkg::cefm_fault_events_t fault_events,
  input wire cefm_pkg::cefm_charger_events_t charger_events,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic int_n
);
  import cefm_pkg::*;

  localparam int FW = $bits(cefm_fault_events_t);
  localparam int CW = $bits(cefm_charger_events_t);
  localparam int LW = 21;

  logic [1:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [FW+CW-1:0] events_sync;
  cefm_fault_events_t flt;
  cefm_charger_events_t chg;
  logic [LW-1:0] levels;
  logic [LW-1:0] rise;
  logic [LW-1:0] change;
  logic [7:0] fault_flags;
  logic [7:0] flag_set;
  logic [7:0] flag_clear;
  logic [7:0] mask_a;
  logic [7:0] mask_b;
  logic [7:0] fault_mask;
  logic [7:0] charger_hit;
  logic [7:0] read_data;
  logic int_trigger;
  logic [15:0] pulse_count;
  cefm_link_state_t state;
  logic [3:0] bit_count;
  logic [7:0] shift;
  logic [7:0] reg_ptr;
  logic read_dir;
  logic write_en;
  logic [7:0] write_addr;
  logic [7:0] write_data;

  cefm_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clock(clock),
    .clock_enable(clock_enable),
    .rst_b(rst_b),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_sync)
  );

  // Analog detectors are asynchronous to this clock
  cefm_sync #(
    .WIDTH(FW + CW)
  ) u_event_sync (
    .clock(clock),
    .clock_enable(clock_enable),
    .rst_b(rst_b),
    .async_in({fault_events, charger_events}),
    .sync_out(events_sync)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];
  assign flt = cefm_fault_events_t'(events_sync[FW+CW-1:CW]);
  assign chg = cefm_charger_events_t'(events_sync[CW-1:0]);

  assign levels = {
    flt.input_overvoltage | flt.input_sleep,
    flt.battery_overcurrent | flt.battery_overvoltage,
    flt.system_overvoltage | flt.system_short,
    flt.boost_reverse_current | flt.mid_node_undervoltage
      | flt.mid_node_overvoltage | flt.input_rail_undervoltage
      | flt.input_rail_overvoltage,
    flt.die_shutdown,
    flt.thermistor_zone,
    chg.conversion_done,
    chg.die_thermal_regulation,
    chg.min_system_voltage_regulation,
    chg.input_current_regulation | chg.current_limit_pin_regulation
      | chg.boost_current_regulation,
    chg.input_voltage_regulation | chg.boost_voltage_regulation,
    chg.fast_timer_expired | chg.trickle_timer_expired
      | chg.precharge_timer_expired,
    chg.host_watchdog_expired,
    chg.charge_state,
    chg.input_supply_state
  };

  cefm_event_edge #(
    .WIDTH(LW)
  ) u_edge (
    .clock(clock),
    .clock_enable(clock_enable),
    .rst_b(rst_b),
    .level(levels),
    .rise(rise),
    .change(change)
  );

  always_comb
  begin
    flag_set = 8'h00;
    flag_set[FLT_INPUT_SUPPLY] = rise[20];
    flag_set[FLT_BATTERY] = rise[19];
    flag_set[FLT_SYSTEM_RAIL] = rise[18];
    flag_set[FLT_BOOST_OUTPUT] = rise[17];
    flag_set[FLT_DIE_OVERHEAT] = rise[16];
    flag_set[FLT_THERMISTOR] = |change[15:13];
  end

  always_comb
  begin
    charger_hit = 8'h00;
    charger_hit[MA_CONVERSION_DONE] = rise[12] & one_shot_mode
      & ~mask_a[MA_CONVERSION_DONE];
    charger_hit[MA_THERMAL_REG] = rise[11] & ~mask_a[MA_THERMAL_REG];
    charger_hit[MA_MIN_SYSTEM] = change[10] & ~mask_a[MA_MIN_SYSTEM];
    charger_hit[MA_INPUT_CURRENT] = rise[9]
      & ~mask_a[MA_INPUT_CURRENT];
    charger_hit[MA_INPUT_VOLTAGE] = rise[8]
      & ~mask_a[MA_INPUT_VOLTAGE];
    charger_hit[MA_CHARGE_TIMER] = rise[7] & ~mask_a[MA_CHARGE_TIMER];
    charger_hit[MA_HOST_WATCHDOG] = rise[6]
      & ~mask_a[MA_HOST_WATCHDOG];
    charger_hit[7] = (|change[5:3]) & ~mask_b[MB_CHARGE_STATE];
  end

  assign int_trigger = (|(flag_set & ~fault_mask))
    | (|charger_hit)
    | ((|change[2:0]) & ~mask_b[MB_INPUT_SUPPLY]);

  // Set wins over the read clear; only bits the host actually saw clear
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      fault_flags <= FAULT_FLAGS_RESET;
    else if (clock_enable)
      fault_flags <= (fault_flags & ~flag_clear) | flag_set;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b || reg_reset)
    begin
      mask_a <= MASK_A_RESET;
      mask_b <= MASK_B_RESET;
      fault_mask <= FAULT_MASK_RESET;
    end
    else if (clock_enable && write_en)
    begin
      case (write_addr)
        ADDR_MASK_A:
          mask_a <= write_data & MASK_A_WRITABLE;
        ADDR_MASK_B:
          mask_b <= write_data & MASK_B_WRITABLE;
        ADDR_FAULT_MASK:
          fault_mask <= write_data & FAULT_MASK_WRITABLE;
        default:
          ;
      endcase
    end
  end

  always_comb
  begin
    case (reg_ptr)
      ADDR_FAULT_FLAGS:
        read_data = fault_flags;
      ADDR_MASK_A:
        read_data = mask_a;
      ADDR_MASK_B:
        read_data = mask_b;
      ADDR_FAULT_MASK:
        read_data = fault_mask;
      default:
        read_data = 8'h00;
    endcase
  end

  // Retrigger restarts the pulse, so a burst reads as one long pulse
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pulse_count <= 16'h0000;
      int_n <= 1'b1;
    end
    else if (clock_enable)
    begin
      if (int_trigger)
      begin
        pulse_count <= 16'(PULSE_CYCLES - 1);
        int_n <= 1'b0;
      end
      else if (pulse_count != 16'h0000)
        pulse_count <= pulse_count - 16'h0001;
      else
        int_n <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      scl_d <= 1'b0;
      sda_d <= 1'b0;
      sda_out <= 1'b0;
    end
    else if (clock_enable)
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      sda_out <= 1'b0;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      bit_count <= 4'h0;
      shift <= 8'h00;
      reg_ptr <= 8'h00;
      read_dir <= 1'b0;
      sda_oe_n <= 1'b1;
      write_en <= 1'b0;
      write_addr <= 8'h00;
      write_data <= 8'h00;
      flag_clear <= 8'h00;
    end
    else if (clock_enable)
    begin
      write_en <= 1'b0;
      flag_clear <= 8'h00;
      if (start_seen)
      begin
        state <= ST_ADDR;
        bit_count <= 4'h0;
        sda_oe_n <= 1'b1;
      end
      else if (stop_seen)
      begin
        state <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_REG, ST_WRITE:
          begin
            if (scl_rise)
            begin
              shift <= {shift[6:0], sda_s};
              bit_count <= bit_count + 4'h1;
            end
            else if (scl_fall && bit_count == 4'h8)
            begin
              bit_count <= 4'h0;
              sda_oe_n <= 1'b0;
              if (state == ST_ADDR)
              begin
                read_dir <= shift[0];
                if (shift[7:1] == SLAVE_ADDR)
                  state <= ST_ADDR_ACK;
                else
                begin
                  state <= ST_IDLE;
                  sda_oe_n <= 1'b1;
                end
              end
              else if (state == ST_REG)
              begin
                reg_ptr <= shift;
                state <= ST_REG_ACK;
              end
              else
              begin
                write_en <= 1'b1;
                write_addr <= reg_ptr;
                write_data <= shift;
                state <= ST_WRITE_ACK;
              end
            end
          end
          ST_ADDR_ACK, ST_READ_NEXT:
          begin
            if (scl_fall && (read_dir || state == ST_READ_NEXT))
            begin
              shift <= read_data;
              sda_oe_n <= read_data[7];
              bit_count <= 4'h1;
              reg_ptr <= reg_ptr + 8'h01;
              if (reg_ptr == ADDR_FAULT_FLAGS)
                flag_clear <= read_data;
              state <= ST_READ;
            end
            else if (scl_fall)
            begin
              sda_oe_n <= 1'b1;
              state <= ST_REG;
            end
          end
          ST_REG_ACK, ST_WRITE_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe_n <= 1'b1;
              state <= ST_WRITE;
              if (state == ST_WRITE_ACK)
                reg_ptr <= reg_ptr + 8'h01;
            end
          end
          ST_READ:
          begin
            if (scl_fall && bit_count == 4'h8)
            begin
              sda_oe_n <= 1'b1;
              bit_count <= 4'h0;
              state <= ST_READ_ACK;
            end
            else if (scl_fall)
            begin
              shift <= {shift[6:0], 1'b0};
              sda_oe_n <= shift[6];
              bit_count <= bit_count + 4'h1;
            end
          end
          ST_READ_ACK:
          begin
            if (scl_rise)
              state <= sda_s ? ST_IDLE : ST_READ_NEXT;
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule : cefm_flag_mask

// [bench/cefm_flag_mask_properties.sv]
`timescale 1ns/1ps
module cefm_flag_mask_properties
  import cefm_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT,
  parameter int PULSE_CYCLES = INT_PULSE_CYCLES
) (
  input wire logic clock,
  input wire logic clock_enable,
  input wire logic rst_b,
  input wire logic reg_reset,
  input wire logic one_shot_mode,
  input wire cefm_pkg::cefm_fault_events_t fault_events,
  input wire cefm_pkg::cefm_charger_events_t charger_events,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic int_n
);
  // Cycles since an event input moved: every pulse needs a recent cause
  logic [7:0] quiet;
  logic [7:0] low_run;
  logic [32:0] prev_ev;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clock)
  begin
    prev_ev <= {fault_events, charger_events};
  end
  always_ff @(posedge clock)
  begin
    if (!rst_b || prev_ev != {fault_events, charger_events})
      quiet <= 8'h00;
    else if (quiet != 8'hFF)
      quiet <= quiet + 8'h01;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_b || int_n)
      low_run <= 8'h00;
    else if (low_run != 8'hFF)
      low_run <= low_run + 8'h01;
  end
  property p_reset_outs;
    disable iff (1'b0) !rst_b |=> int_n && sda_oe_n && !sda_out;
  endproperty
  a_reset_outs: assert property (p_reset_outs)
    else $error("outputs not idle after reset");
  property p_sda_low;
    !sda_oe_n |-> !sda_out;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data pin driven high");
  property p_oe_edge;
    $changed(sda_oe_n) |-> $past(scl_in, 6) && !$past(scl_in, 2);
  endproperty
  a_oe_edge: assert property (p_oe_edge)
    else $error("data drive moved away from a clock fall");
  property p_oe_hold;
    $changed(sda_oe_n) |=> $stable(sda_oe_n) [*6];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("data drive did not stand");
  property p_oe_fall_low;
    $fell(sda_oe_n) |-> !scl_in;
  endproperty
  a_oe_fall_low: assert property (p_oe_fall_low)
    else $error("data pulled low while clock high");
  property p_int_cause;
    $fell(int_n) |-> quiet <= 8'h06;
  endproperty
  a_int_cause: assert property (p_int_cause)
    else $error("interrupt without an event");
  property p_int_min;
    $rose(int_n) |-> low_run >= 8'(PULSE_CYCLES);
  endproperty
  a_int_min: assert property (p_int_min)
    else $error("interrupt pulse too short");
  property p_int_max;
    !int_n |-> quiet <= 8'(PULSE_CYCLES + 6);
  endproperty
  a_int_max: assert property (p_int_max)
    else $error("interrupt pulse too long");
endmodule : cefm_flag_mask_properties

bind cefm_flag_mask cefm_flag_mask_properties #(
  .SLAVE_ADDR(SLAVE_ADDR),
  .PULSE_CYCLES(PULSE_CYCLES)
) cefm_flag_mask_properties_i (
  .clock(clock),
  .clock_enable(clock_enable),
  .rst_b(rst_b),
  .reg_reset(reg_reset),
  .one_shot_mode(one_shot_mode),
  .fault_events(fault_events),
  .charger_events(charger_events),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .int_n(int_n)
);

// [bench/cefm_host_model.sv]
`timescale 1ns/1ps
module cefm_host_model (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv,
  output logic [7:0] res,
  output logic res_stb
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    res = 8'h00;
    res_stb = 1'b0;
  end
  // Eight cycles per half bit leaves margin over the six the slave needs
  task automatic hp();
    repeat (8) @(posedge clock);
  endtask : hp
  task automatic emit(input logic [7:0] v);
    res <= v;
    res_stb <= 1'b1;
    @(posedge clock);
    res_stb <= 1'b0;
  endtask : emit
  task automatic start();
    sda_drv <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_drv <= 1'b0;
    hp();
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    sda_drv <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_drv <= 1'b1;
    hp();
  endtask : stop
  task automatic xfer_bit(input logic b, output logic got);
    sda_drv <= b;
    hp();
    scl <= 1'b1;
    hp();
    got = sda_line;
    scl <= 1'b0;
  endtask : xfer_bit
  // Reports the slave acknowledge on writes, the byte on reads
  task automatic xfer_byte(input logic [7:0] d, input logic rd);
    logic [7:0] got;
    logic a;
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], got[i]);
    // Ack slot released: the slave acks writes, the single read ends in nack
    xfer_bit(1'b1, a);
    emit(rd ? got : {7'h00, a});
  endtask : xfer_byte
  task automatic access(input logic [6:0] dev, input logic [7:0] regn,
                        input logic wr, input logic [7:0] d);
    start();
    xfer_byte({dev, 1'b0}, 1'b0);
    xfer_byte(regn, 1'b0);
    if (wr)
      xfer_byte(d, 1'b0);
    else
    begin
      start();
      xfer_byte({dev, 1'b1}, 1'b0);
      xfer_byte(8'hFF, 1'b1);
    end
    stop();
  endtask : access
endmodule : cefm_host_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("mismatch t=%0t got %0h exp %0h", $time, a, b); \
    end \
  end
module tb_top;
  import cefm_pkg::*;
  localparam logic [6:0] DEV = SLAVE_ADDR_DEFAULT;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic reg_reset = 1'b0;
  logic one_shot_mode = 1'b1;
  cefm_fault_events_t fault_events = '0;
  cefm_charger_events_t charger_events = '0;
  logic scl, sda_drv, sda_line, sda_out, sda_oe_n, int_n, res_stb;
  logic [7:0] res, exp_v;
  logic [7:0] expq[$];
  logic [31:0] seed = 32'h00018073;
  int errors = 0;
  int num_checks = 0;
  always #5 clock = ~clock;
  // Open-drain line with pull-up: low when either side pulls
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  cefm_flag_mask #(
    .SLAVE_ADDR(DEV),
    .PULSE_CYCLES(4)
  ) cefm_flag_mask_i (
    .clock(clock),
    .clock_enable(1'b1),
    .rst_b(rst_b),
    .reg_reset(reg_reset),
    .one_shot_mode(one_shot_mode),
    .fault_events(fault_events),
    .charger_events(charger_events),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .int_n(int_n)
  );
  cefm_host_model host_i (
    .clock(clock),
    .sda_line(sda_line),
    .scl(scl),
    .sda_drv(sda_drv),
    .res(res),
    .res_stb(res_stb)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] flag_of(input int i);
    if (i >= 13) return 8'h80;
    if (i >= 11) return 8'h40;
    if (i >= 9) return 8'h20;
    if (i >= 4) return 8'h10;
    return 8'h08;
  endfunction : flag_of
  function automatic logic [15:0] ch_mask(input int i);
    if (i == 17) return {ADDR_MASK_A, 8'h40};
    if (i == 16) return {ADDR_MASK_A, 8'h20};
    if (i == 15) return {ADDR_MASK_A, 8'h10};
    if (i >= 12) return {ADDR_MASK_A, 8'h08};
    if (i >= 10) return {ADDR_MASK_A, 8'h04};
    if (i >= 7) return {ADDR_MASK_A, 8'h02};
    if (i == 6) return {ADDR_MASK_A, 8'h01};
    if (i >= 3) return {ADDR_MASK_B, 8'h08};
    return {ADDR_MASK_B, 8'h01};
  endfunction : ch_mask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    repeat (3) expq.push_back(8'h00);
    host_i.access(DEV, r, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] r, input logic [7:0] e);
    repeat (3) expq.push_back(8'h00);
    expq.push_back(e);
    host_i.access(DEV, r, 1'b0, 8'h00);
  endtask : rd
  // Fixed window: detection plus a four-cycle pulse fits in twelve
  task automatic int_check(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (12)
    begin
      @(posedge clock);
      if (int_n === 1'b0)
        seen = 1'b1;
    end
    `CHK(seen, e)
    repeat (8) @(posedge clock);
  endtask : int_check
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  always @(posedge clock)
  begin
    if (res_stb === 1'b1)
    begin
      exp_v = expq.size() > 0 ? expq.pop_front() : 8'hXX;
      `CHK(res, exp_v)
    end
  end
  initial
  begin
    repeat (90000) @(posedge clock);
    errors++;
    test_done();
  end
  initial
  begin
    logic [15:0] mk;
    logic [7:0] d;
    logic [2:0] z;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (6) @(posedge clock);
    for (int r = 8'h22; r < 8'h27; r++)
      rd(8'(r), 8'h00);
    repeat (2)
    begin
      d = 8'(rnd());
      wr(ADDR_MASK_A, d);
      rd(ADDR_MASK_A, d & MASK_A_WRITABLE);
      wr(ADDR_MASK_B, d);
      rd(ADDR_MASK_B, d & MASK_B_WRITABLE);
      wr(ADDR_FAULT_MASK, d);
      rd(ADDR_FAULT_MASK, d & FAULT_MASK_WRITABLE);
    end
    wr(ADDR_MASK_A, 8'hFF);
    wr(ADDR_MASK_B, 8'hFF);
    wr(ADDR_FAULT_MASK, 8'hFF);
    reg_reset <= 1'b1;
    @(posedge clock);
    reg_reset <= 1'b0;
    for (int r = 8'h23; r < 8'h26; r++)
      rd(8'(r), 8'h00);
    wr(ADDR_FAULT_FLAGS, 8'hFF);
    rd(ADDR_FAULT_FLAGS, 8'h00);
    repeat (3) expq.push_back(8'h01);
    host_i.access(DEV ^ 7'h01, ADDR_MASK_A, 1'b1, 8'hFF);
    rd(ADDR_MASK_A, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_FAULT_MASK, m ? 8'hFF : 8'h00);
      for (int i = 3; i < 15; i++)
      begin
        fault_events[i] <= 1'b1;
        int_check(!m);
        fault_events[i] <= 1'b0;
        rd(ADDR_FAULT_FLAGS, flag_of(i));
        rd(ADDR_FAULT_FLAGS, 8'h00);
      end
      z = 3'(rnd());
      if (z == fault_events[2:0])
        z = ~z;
      fault_events[2:0] <= z;
      int_check(!m);
      rd(ADDR_FAULT_FLAGS, 8'h01);
    end
    for (int m = 0; m < 2; m++)
    begin
      for (int i = 0; i < 18; i++)
      begin
        mk = ch_mask(i);
        if (m)
          wr(mk[15:8], mk[7:0]);
        charger_events[i] <= 1'b1;
        int_check(!m);
        charger_events[i] <= 1'b0;
        int_check(!m && (i < 6 || i == 15));
        if (m)
          wr(mk[15:8], 8'h00);
      end
    end
    one_shot_mode <= 1'b0;
    charger_events[17] <= 1'b1;
    int_check(1'b0);
    // Mid-run reset with event levels still present at release
    wr(ADDR_MASK_A, 8'hFF);
    rst_b <= 1'b0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (6) @(posedge clock);
    rd(ADDR_MASK_A, 8'h00);
    rd(ADDR_FAULT_FLAGS, 8'h00);
    repeat (20) @(posedge clock);
    `CHK(expq.size(), 0)
    test_done();
  end
endmodule : tb_top
